// [hw/drpwm_pkg.sv]
// Package for the dual resolution modulator bank
package drpwm_pkg;
	localparam int unsigned NUM_CH = 10;
	localparam int unsigned NUM_COARSE = 9;
	localparam int unsigned FINE_HI_W = 8;
	localparam int unsigned FINE_LO_W = 6;
	localparam int unsigned COARSE_W = 7;
	localparam int unsigned SUB_W = 6;
	localparam int unsigned SUB_CNT_W = 9;
	localparam int unsigned COARSE_CNT_W = 8;
	localparam int unsigned SEL_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [SEL_W-1:0] SEL_FINE_LO = 8'h00;
	localparam logic [SEL_W-1:0] SEL_FINE_HI = 8'h01;
	localparam logic [SEL_W-1:0] SEL_COARSE_BASE = 8'h02;
	localparam logic [SEL_W-1:0] CMD_TRANSFER = 8'h0c;
	localparam int unsigned STATUS_PEND_BIT = 7;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [SUB_W-1:0] SUB_LAST = 6'h3f;
	localparam logic [COARSE_CNT_W-1:0] COARSE_LAST = 8'hff;
	localparam logic [SUB_CNT_W-1:0] SUB_PERIOD_LAST = 9'h1ff;

	// One software access to the modulator registers
	typedef struct packed {
		logic ctrl_we;
		logic buf_we;
		logic [DATA_W-1:0] wdata;
	} drpwm_wr_t;

	// Shadow contents for the fine channel
	typedef struct packed {
		logic [FINE_HI_W-1:0] hi;
		logic [FINE_LO_W-1:0] lo;
	} drpwm_fine_t;
endpackage

// [hw/drpwm_coarse_ch.sv]
// One coarse 7-bit modulated channel
`timescale 1ns/100ps
`default_nettype none
module drpwm_coarse_ch #(
	parameter int unsigned W = drpwm_pkg::COARSE_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Shared period counter and new data
	input wire logic [drpwm_pkg::COARSE_CNT_W-1:0] cnt_i,
	input wire logic load_i,
	input wire logic [W-1:0] data_i,
	// Modulated output
	output logic pwm_o
);
	logic [W-1:0] active_q, active_d;
	logic pwm_q, pwm_d;

	// Next width and output level
	always_comb begin
		active_d = active_q;
		if (load_i && cnt_i == drpwm_pkg::COARSE_LAST) begin
			active_d = data_i;
		end
		// High for k times two clocks of the 256-clock period
		pwm_d = ({1'b0, cnt_i[drpwm_pkg::COARSE_CNT_W-1:1]} <
			{1'b0, active_q});
	end

	// State registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			active_q <= '0;
			pwm_q <= 1'b0;
		end else begin
			active_q <= active_d;
			pwm_q <= pwm_d;
		end
	end

	assign pwm_o = pwm_q;
endmodule
`default_nettype wire

// [hw/drpwm_fine_ch.sv]
// Fine 14-bit modulated channel
`timescale 1ns/100ps
`default_nettype none
module drpwm_fine_ch (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Period counters and new data
	input wire logic [drpwm_pkg::SUB_W-1:0] sub_i,
	input wire logic [drpwm_pkg::SUB_CNT_W-1:0] cnt_i,
	input wire logic load_i,
	input wire drpwm_pkg::drpwm_fine_t data_i,
	// Modulated output
	output logic pwm_o
);
	drpwm_pkg::drpwm_fine_t active_q, active_d;
	logic pwm_q, pwm_d;
	logic extra;
	logic [drpwm_pkg::FINE_HI_W:0] width;

	// Extra pulse placement by lowest set bit of the sub-period index
	always_comb begin
		unique casez (sub_i)
			6'b?????1: extra = active_q.lo[5];
			6'b????10: extra = active_q.lo[4];
			6'b???100: extra = active_q.lo[3];
			6'b??1000: extra = active_q.lo[2];
			6'b?10000: extra = active_q.lo[1];
			6'b100000: extra = active_q.lo[0];
			default: extra = 1'b0;
		endcase
	end

	// Width n plus an optional extra step of two clocks
	always_comb begin
		width = {1'b0, active_q.hi} + {8'h00, extra};
		active_d = active_q;
		if (load_i && sub_i == drpwm_pkg::SUB_LAST &&
			cnt_i == drpwm_pkg::SUB_PERIOD_LAST) begin
			active_d = data_i;
		end
		pwm_d = (cnt_i[drpwm_pkg::SUB_CNT_W-1:1] < width);
	end

	// State registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			active_q <= '0;
			pwm_q <= 1'b0;
		end else begin
			active_q <= active_d;
			pwm_q <= pwm_d;
		end
	end

	assign pwm_o = pwm_q;
endmodule
`default_nettype wire

// [hw/drpwm_bank.sv]
// Top of the ten-channel dual resolution modulator bank
// Functional notes
// - Ten outputs: one fine channel and nine coarse channels on port pins.
// - Fine channel has 14-bit resolution, period 2^15 clocks.
// - 64 sub-periods; upper byte gives width n times two clocks.
// - Lower six bits add extra pulses in m of 64 sub-periods.
// - Extra pulse positions follow the binary-weighted sub-period table.
// - Coarse channels: 7-bit, period 256 clocks, width k times two.
// - Loading via control register, data buffer; status reports pending transfer.
// - Pending flag stays one during transfer and clears when done.
// - Select codes 00h, 01h fine, 02h to 0Ah coarse; pending bit 7.
// - Channels keep old data until the transfer takes effect.
// - Switch within 2^15 clocks fine, 2^8 clocks coarse.
`timescale 1ns/100ps
`default_nettype none
module drpwm_bank #(
	parameter int unsigned NCOARSE = drpwm_pkg::NUM_COARSE
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// Software access
	input wire logic CTRL_WE_I,
	input wire logic BUF_WE_I,
	input wire logic [drpwm_pkg::DATA_W-1:0] WDATA_I,
	// Status and control readback
	output logic [drpwm_pkg::DATA_W-1:0] STATUS_O,
	output logic [drpwm_pkg::SEL_W-1:0] SELECT_O,
	// Modulated outputs
	output logic FINE_PWM_O,
	output logic [NCOARSE-1:0] COARSE_PWM_O
);
	// Software write bundle and its decode
	drpwm_pkg::drpwm_wr_t wr;
	logic is_xfer;
	logic is_select;
	logic hit_fine_lo;
	logic hit_fine_hi;
	logic hit_fine;
	logic [NCOARSE-1:0] hit_coarse;
	// Latch select register
	logic [drpwm_pkg::SEL_W-1:0] sel_q, sel_d;
	// Shadow latches filled through the data buffer
	drpwm_pkg::drpwm_fine_t fine_sh_q, fine_sh_d;
	logic [drpwm_pkg::COARSE_W-1:0] coarse_sh_q [NCOARSE];
	logic [drpwm_pkg::COARSE_W-1:0] coarse_sh_d [NCOARSE];
	// Fine transfer sequencer and coarse pending flags
	typedef enum logic {
		FINE_IDLE,
		FINE_ARMED
	} drpwm_fine_st_t;
	drpwm_fine_st_t fst_q, fst_d;
	logic fine_armed;
	logic [NCOARSE-1:0] pend_c_q, pend_c_d;
	// Period counters and their boundaries
	logic [drpwm_pkg::SUB_W-1:0] sub_q, sub_d;
	logic [drpwm_pkg::SUB_CNT_W-1:0] fcnt_q, fcnt_d;
	logic [drpwm_pkg::COARSE_CNT_W-1:0] ccnt_q, ccnt_d;
	logic fine_end, coarse_end;
	// Status byte
	logic [drpwm_pkg::DATA_W-1:0] status_q, status_d;

	// Select code of a coarse channel
	function automatic logic [drpwm_pkg::SEL_W-1:0] coarse_code(
		input int idx
	);
		logic [drpwm_pkg::SEL_W-1:0] offs;
		offs = idx[drpwm_pkg::SEL_W-1:0];
		coarse_code = drpwm_pkg::SEL_COARSE_BASE + offs;
	endfunction

	// Bundle the software write
	assign wr = '{ctrl_we: CTRL_WE_I, buf_we: BUF_WE_I, wdata: WDATA_I};

	// Control write decode; the transfer code is never a select
	always_comb begin
		is_xfer = wr.ctrl_we && (wr.wdata == drpwm_pkg::CMD_TRANSFER);
		is_select = wr.ctrl_we && !is_xfer;
	end

	// Channel addressed by the current select code
	always_comb begin
		hit_fine_lo = (sel_q == drpwm_pkg::SEL_FINE_LO);
		hit_fine_hi = (sel_q == drpwm_pkg::SEL_FINE_HI);
		hit_fine = hit_fine_lo || hit_fine_hi;
		for (int i = 0; i < NCOARSE; i++) begin
			hit_coarse[i] = (sel_q == coarse_code(i));
		end
	end

	// Period boundaries of the shared counters
	assign coarse_end = (ccnt_q == drpwm_pkg::COARSE_LAST);
	assign fine_end = (sub_q == drpwm_pkg::SUB_LAST) &&
		(fcnt_q == drpwm_pkg::SUB_PERIOD_LAST);

	// Fine sub-period counter and sub-period index
	always_comb begin
		fcnt_d = fcnt_q + 9'h001;
		sub_d = sub_q;
		if (fcnt_q == drpwm_pkg::SUB_PERIOD_LAST) begin
			sub_d = sub_q + 6'h01;
		end
	end

	// Fine counter registers
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sub_q <= '0;
			fcnt_q <= '0;
		end else begin
			sub_q <= sub_d;
			fcnt_q <= fcnt_d;
		end
	end

	// Coarse period counter, wraps every 256 clocks
	always_comb begin
		ccnt_d = ccnt_q + 8'h01;
	end

	// Coarse counter register
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ccnt_q <= '0;
		end else begin
			ccnt_q <= ccnt_d;
		end
	end

	// Next select code
	always_comb begin
		sel_d = sel_q;
		if (is_select) begin
			sel_d = wr.wdata;
		end
	end

	// Select register
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sel_q <= '0;
		end else begin
			sel_q <= sel_d;
		end
	end

	// Buffer writes land in the addressed shadow latch
	always_comb begin
		fine_sh_d = fine_sh_q;
		coarse_sh_d = coarse_sh_q;
		if (wr.buf_we && hit_fine_lo) begin
			fine_sh_d.lo = wr.wdata[drpwm_pkg::FINE_LO_W-1:0];
		end
		if (wr.buf_we && hit_fine_hi) begin
			fine_sh_d.hi = wr.wdata;
		end
		for (int i = 0; i < NCOARSE; i++) begin
			if (wr.buf_we && hit_coarse[i]) begin
				coarse_sh_d[i] = wr.wdata[drpwm_pkg::COARSE_W-1:0];
			end
		end
	end

	// Shadow registers; channels keep running on their own copy
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fine_sh_q <= '0;
			for (int i = 0; i < NCOARSE; i++) begin
				coarse_sh_q[i] <= '0;
			end
		end else begin
			fine_sh_q <= fine_sh_d;
			coarse_sh_q <= coarse_sh_d;
		end
	end

	// Fine sequencer: armed by a transfer, idle once the period restarts
	always_comb begin
		fst_d = fst_q;
		unique case (fst_q)
			FINE_IDLE: begin
				if (is_xfer && hit_fine) begin
					fst_d = FINE_ARMED;
				end
			end
			FINE_ARMED: begin
				// A transfer in the boundary cycle keeps it armed
				if (fine_end && !(is_xfer && hit_fine)) begin
					fst_d = FINE_IDLE;
				end
			end
		endcase
	end

	// Fine sequencer register
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fst_q <= FINE_IDLE;
		end else begin
			fst_q <= fst_d;
		end
	end

	// Fine channel reloads at its period start while armed
	assign fine_armed = (fst_q == FINE_ARMED);

	// Coarse pending: set by a transfer, cleared at the period start
	always_comb begin
		pend_c_d = pend_c_q;
		if (coarse_end) begin
			pend_c_d = '0;
		end
		// Set wins over a clear in the same cycle
		if (is_xfer) begin
			pend_c_d = pend_c_d | hit_coarse;
		end
	end

	// Coarse pending register
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pend_c_q <= '0;
		end else begin
			pend_c_q <= pend_c_d;
		end
	end

	// Status byte with the pending flag at its bit, spare bits zero
	always_comb begin
		status_d = drpwm_pkg::STATUS_RESET;
		status_d[drpwm_pkg::STATUS_PEND_BIT] =
			(fst_d == FINE_ARMED) | (|pend_c_d);
	end

	// Status register
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			status_q <= drpwm_pkg::STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	assign STATUS_O = status_q;
	assign SELECT_O = sel_q;

	// Fine channel keeps old data until its period ends
	drpwm_fine_ch u_fine (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.sub_i(sub_q),
		.cnt_i(fcnt_q),
		.load_i(fine_armed),
		.data_i(fine_sh_q),
		.pwm_o(FINE_PWM_O)
	);

	// Nine coarse channels
	for (genvar g = 0; g < NCOARSE; g++) begin : g_coarse
		drpwm_coarse_ch #(
			.W(drpwm_pkg::COARSE_W)
		) u_coarse (
			.clk_i(CLK_I),
			.rstn_i(RSTN_I),
			.cnt_i(ccnt_q),
			.load_i(pend_c_q[g]),
			.data_i(coarse_sh_q[g]),
			.pwm_o(COARSE_PWM_O[g])
		);
	end
endmodule
`default_nettype wire

// [sim/drpwm_bank_properties.sv]
// Port checker for the modulator bank
`timescale 1ns/100ps
`default_nettype none
module drpwm_bank_properties #(
	parameter int unsigned NCOARSE = 9
) (
	// Clock, reset and writes
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CTRL_WE_I,
	input wire logic BUF_WE_I,
	input wire logic [7:0] WDATA_I,
	// Readback and outputs
	input wire logic [7:0] STATUS_O,
	input wire logic [7:0] SELECT_O,
	input wire logic FINE_PWM_O,
	input wire logic [NCOARSE-1:0] COARSE_PWM_O
);
	logic [15:0] pc_q, hl_q;
	logic cmd;
	assign cmd = CTRL_WE_I && WDATA_I == drpwm_pkg::CMD_TRANSFER;
	// Pending time and first coarse high run
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pc_q <= '0;
			hl_q <= '0;
		end else begin
			pc_q <= STATUS_O[7] ? pc_q + 16'h1 : '0;
			hl_q <= COARSE_PWM_O[0] ? hl_q + 16'h1 : '0;
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	chk_status_spare: assert property (STATUS_O[6:0] == 7'h00)
		else $error("status spare bits set");
	chk_pend_set: assert property (cmd &&
		SELECT_O < drpwm_pkg::SEL_COARSE_BASE + 8'(NCOARSE) |=> STATUS_O[7])
		else $error("pending not set");
	chk_pend_cause: assert property ($rose(STATUS_O[7]) |-> $past(cmd))
		else $error("pending set without command");
	chk_sel_store: assert property (CTRL_WE_I && !cmd |=>
		SELECT_O == $past(WDATA_I)) else $error("select not stored");
	chk_sel_hold: assert property (cmd |=> $stable(SELECT_O))
		else $error("select changed by command");
	chk_pend_bound: assert property (pc_q <= 16'h8002)
		else $error("pending too long");
	chk_coarse_run: assert property ($fell(COARSE_PWM_O[0]) |->
		!hl_q[0] && hl_q <= 16'h00fe) else $error("coarse width bad");
	chk_reset_outs: assert property ($rose(RSTN_I) |->
		STATUS_O == 8'h00 && !FINE_PWM_O && COARSE_PWM_O == '0)
		else $error("outputs not clear after reset");
endmodule
bind drpwm_bank drpwm_bank_properties #(.NCOARSE(NCOARSE)) chk_i (
	.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CTRL_WE_I(CTRL_WE_I),
	.BUF_WE_I(BUF_WE_I), .WDATA_I(WDATA_I), .STATUS_O(STATUS_O),
	.SELECT_O(SELECT_O), .FINE_PWM_O(FINE_PWM_O),
	.COARSE_PWM_O(COARSE_PWM_O));
`default_nettype wire

// [sim/drpwm_port_pin.sv]
// Port pin with output latch and a high-time meter
`timescale 1ns/100ps
`default_nettype none
module drpwm_port_pin (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Latch, modulated signal, meter clear
	input wire logic latch_i,
	input wire logic pwm_i,
	input wire logic clr_i,
	// Pin level and counted high cycles
	output logic pin_o,
	output logic [15:0] hi_o
);
	logic [15:0] hi_d;
	// Pin follows the modulator only with latch set
	assign pin_o = latch_i & pwm_i;
	// Filter stand-in counts high cycles
	always_comb begin
		hi_d = clr_i ? 16'h0000 : hi_o + {15'h0000, pin_o};
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hi_o <= '0;
		end else begin
			hi_o <= hi_d;
		end
	end
endmodule
`default_nettype wire

// [sim/drpwm_bank_tb.sv]
// Testbench for the modulator bank
`timescale 1ns/100ps
`default_nettype none
module drpwm_bank_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ctrl = 1'b0;
	logic bufw = 1'b0;
	logic clr = 1'b0;
	logic [7:0] wd = 8'h00;
	logic [7:0] status, sel;
	logic fine;
	logic [8:0] coarse;
	logic [15:0] hi;
	logic [3:0] ch = 4'h0;
	int fails = 0, cmp_count = 0, cyc = 0, n;
	drpwm_bank DUT (.CLK_I(clk), .RSTN_I(rst_n), .CTRL_WE_I(ctrl),
		.BUF_WE_I(bufw), .WDATA_I(wd), .STATUS_O(status),
		.SELECT_O(sel), .FINE_PWM_O(fine), .COARSE_PWM_O(coarse));
	drpwm_port_pin pp (.clk_i(clk), .rstn_i(rst_n), .latch_i(1'b1),
		.pwm_i(ch == 4'h0 ? fine : coarse[ch - 4'h1]), .clr_i(clr),
		.pin_o(), .hi_o(hi));
	// Clock and cycle ceiling
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails = fails + 1;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	// One register write, strobe held for one edge
	task automatic wr(input logic c, input logic [7:0] v);
		@(posedge clk);
		ctrl <= c;
		bufw <= !c;
		wd <= v;
		@(posedge clk);
		ctrl <= 1'b0;
		bufw <= 1'b0;
		#1;
	endtask
	// Select a latch and fill it through the buffer
	task automatic put(input logic [7:0] s, v);
		wr(1'b1, s);
		chk("select", {8'h00, sel}, {8'h00, s});
		wr(1'b0, v);
	endtask
	// Transfer command, then poll pending
	task automatic xfer(input int lim);
		wr(1'b1, drpwm_pkg::CMD_TRANSFER);
		chk("pending", {8'h00, status}, 16'h0080);
		n = 0;
		while (status[7] !== 1'b0 && n < 40000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("status", {8'h00, status}, 16'h0000);
		chk("delay", 16'(n <= lim), 16'h0001);
	endtask
	// High cycles of the selected pin over a window
	task automatic meas(input string nm, input int len, input logic [15:0] e);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (len) @(posedge clk);
		#1;
		chk(nm, hi, e);
	endtask
	task automatic end_sim();
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("reset", {8'h00, status}, 16'h0000);
		// Fine: 3 steps base, extra in 43 of 64; both halves, one transfer
		put(drpwm_pkg::SEL_FINE_LO, 8'h2b);
		put(drpwm_pkg::SEL_FINE_HI, 8'h03);
		xfer(32770);
		meas("fine", 32768, 16'h01d6);
		// Every coarse channel, widths up to the top code
		for (int i = 0; i < 9; i++) begin
			ch <= 4'(i + 1);
			put(8'(i + 2), 8'(i == 8 ? 127 : i * 15 + 5));
			xfer(514);
			meas("coarse", 256, 16'(2 * (i == 8 ? 127 : i * 15 + 5)));
		end
		end_sim();
	end
endmodule
`default_nettype wire
